// >>> shared/adcseq_regs.vh
// Purpose: register map and timing constants of the conversion sequencer
// Assumes: word-aligned Avalon-MM byte addresses, 8-bit registers in low bits
// Notes: offsets are local choices
`ifndef ADCSEQ_REGS_VH
`define ADCSEQ_REGS_VH
`define ADCSEQ_ADDR_W 4
`define ADCSEQ_OFF_RESULT_HIGH 4'h0
`define ADCSEQ_OFF_RESULT_LOW 4'h4
`define ADCSEQ_OFF_CHANNEL_START 4'h8
`define ADCSEQ_OFF_REF_PIN 4'hC
// timing/format register sits at 0x10; only its index bit differs
`define ADCSEQ_IDX_TIMING_FORMAT 3'h4
`define ADCSEQ_BIT_ENABLE 0
`define ADCSEQ_BIT_START 1
`define ADCSEQ_CHAN_LSB 2
`define ADCSEQ_BIT_JUSTIFY 7
`define ADCSEQ_ACQ_LSB 3
`define ADCSEQ_REF_NEG_BIT 5
`define ADCSEQ_REF_POS_BIT 4
`define ADCSEQ_PCFG_ANALOG 4'h0
`define ADCSEQ_PCFG_DIGITAL 4'h7
`define ADCSEQ_TRIG_MODE 4'hB
`define ADCSEQ_RESTART_CYC 2
`define ADCSEQ_TCY_DIV 4
`define ADCSEQ_RC_DIV 8
`define ADCSEQ_RES_BITS 12
`endif

// >>> rtl/adcseq_core.v
// Purpose: control logic of a successive-approximation converter
// Assumes: one 50 MHz clock; comparator input from analog sample-and-hold
// Notes: registers reached over Avalon-MM with one wait cycle
// Notes: writes land at the edge where waitrequest is sampled low
// Notes: result pair is cleared by the power-on reset only
// Notes on behaviour
// - reset clears control, stops any conversion
// - done loads result, clears start, sets flag
// - result pair survives the ordinary reset, not power-on
// - nonzero acquisition setting runs acquisition first
// - setting 010 gives four bit periods acquisition
// - setting 000 delays start one instruction cycle
// - clearing start aborts, result kept unchanged
// - two instruction cycles then auto acquire
// - one result bit per conversion bit period
// - discharge holding array before every sample
// - reference select: supply rails or external pins
// - acquisition counts bit periods, scaled by clock
// - analog-configured pins read zero
// - strap chooses port b reset pin config
// - mode 1011 trigger starts and clears timer
// - disabled converter ignores trigger, timer cleared
`include "adcseq_regs.vh"
module adcseq_core #(
  parameter RES_BITS = `ADCSEQ_RES_BITS,
  parameter NPINS = 13
) (
  input wire core_clk,
  input wire rst_b,
  input wire por_b,
  input wire [`ADCSEQ_ADDR_W+1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire portb_analog_reset_config,
  input wire [3:0] second_capture_compare_mode,
  input wire special_event_trigger,
  input wire [NPINS-1:0] pin_digital_in,
  input wire comparator_high,
  output reg [NPINS-1:0] port_read_value,
  output reg timer_counter_clear,
  output reg conversion_complete_flag,
  output reg sample_switch_closed,
  output reg holding_discharge,
  output reg [RES_BITS-1:0] dac_code,
  output reg [3:0] channel_select,
  output reg negative_reference_select,
  output reg positive_reference_select,
  output reg [3:0] analog_pin_config
);
  localparam ST_IDLE = 6'b000001;
  localparam ST_DELAY = 6'b000010;
  localparam ST_DISCH = 6'b000100;
  localparam ST_ACQ = 6'b001000;
  localparam ST_CONV = 6'b010000;
  localparam ST_WAIT = 6'b100000;
  localparam [4:0] RESTART_STEPS = `ADCSEQ_RESTART_CYC;
  localparam [7:0] RC_DIV = `ADCSEQ_RC_DIV;
  localparam [7:0] TCY_LAST = `ADCSEQ_TCY_DIV - 1;
  localparam [RES_BITS-1:0] SAR_FIRST = {1'b1, {(RES_BITS - 1){1'b0}}};

  // acquisition length in bit periods per setting
  function [4:0] acq_periods;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: acq_periods = 5'h00;
        3'h1: acq_periods = 5'h02;
        3'h2: acq_periods = 5'h04;
        3'h3: acq_periods = 5'h06;
        3'h4: acq_periods = 5'h08;
        3'h5: acq_periods = 5'h0C;
        3'h6: acq_periods = 5'h10;
        default: acq_periods = 5'h14;
      endcase
    end
  endfunction

  // divider from core clock cycles to one bit period
  function [7:0] tad_div;
    input [2:0] sel;
    begin
      case (sel[1:0])
        2'h0: tad_div = 8'h02;
        2'h1: tad_div = 8'h08;
        2'h2: tad_div = 8'h20;
        default: tad_div = RC_DIV;
      endcase
      if (sel[2] && sel[1:0] != 2'h3) begin
        tad_div = {tad_div[6:0], 1'b0};
      end
    end
  endfunction

  // is pin i analog under the pin-config field (lower pins first)
  function pin_analog;
    input [3:0] cfg;
    input integer idx;
    begin
      pin_analog = (idx < (15 - cfg)) && (cfg != 4'hF);
    end
  endfunction

  // next trial word: keep or drop the bit under test, then try the next lower one
  function [RES_BITS-1:0] sar_next;
    input [RES_BITS-1:0] cur;
    input [RES_BITS-1:0] trial;
    input keep;
    reg [RES_BITS-1:0] low;
    begin
      low = trial & ~(trial - {{(RES_BITS - 1){1'b0}}, 1'b1});
      sar_next = cur ^ ({RES_BITS{~keep}} & low) ^ (low >> 1);
    end
  endfunction

  // write strobe for one register index
  function reg_write;
    input [2:0] target;
    input hit;
    input [2:0] index;
    begin
      reg_write = hit & (index == target);
    end
  endfunction

  reg [7:0] res_hi_q;
  reg [7:0] res_lo_q;
  reg enable_q;
  reg start_q;
  reg justify_q;
  reg [2:0] acq_sel_q;
  reg [2:0] clk_sel_q;
  reg [5:0] state_q;
  reg [7:0] tcy_cnt_q;
  reg [7:0] tad_cnt_q;
  reg [4:0] step_q;
  reg [RES_BITS-1:0] sar_q;
  reg tad_tick;
  reg tcy_tick;
  reg [7:0] rd_byte;
  reg [15:0] result_word;
  integer i;

  // first edge of a request: read data loads here so it stands at the answer edge
  wire req_first = (avs_read | avs_write) & avs_waitrequest;
  wire rd_first = req_first & avs_read;
  // a transfer completes at the edge where waitrequest is low
  wire acc = (avs_read | avs_write) & ~avs_waitrequest;
  wire wr_any = acc & avs_write;
  wire [2:0] idx = avs_address[4:2];
  wire wr_ctl = wr_any & ({idx, 2'b00} == {1'b0, `ADCSEQ_OFF_CHANNEL_START});
  wire wr_res_hi = reg_write(3'h0, wr_any, idx);
  wire wr_res_lo = reg_write(3'h1, wr_any, idx);
  wire wr_ref = reg_write(3'h3, wr_any, idx);
  wire wr_timing = reg_write(`ADCSEQ_IDX_TIMING_FORMAT, wr_any, idx);
  wire wr_flag = reg_write(3'h7, wr_any, idx);
  wire conv_done = (state_q == ST_CONV) & tad_tick & (step_q == 5'h00);
  wire sw_go = wr_ctl & avs_writedata[`ADCSEQ_BIT_START];
  wire sw_clear = wr_ctl & ~avs_writedata[`ADCSEQ_BIT_START];
  // trigger honoured only in mode 1011 with converter on
  wire trig_mode = (second_capture_compare_mode == `ADCSEQ_TRIG_MODE);
  wire trig_go = trig_mode & special_event_trigger & enable_q;
  wire busy = (state_q != ST_IDLE) && (state_q != ST_WAIT);
  wire start_req = (sw_go & enable_q) | trig_go;
  wire [4:0] acq_len = acq_periods(acq_sel_q);

  always @* begin
    tcy_tick = (tcy_cnt_q == TCY_LAST);
    tad_tick = (tad_cnt_q == tad_div(clk_sel_q) - 8'h01);
    result_word = justify_q ? {{(16 - RES_BITS){1'b0}}, sar_q}
                            : {sar_q, {(16 - RES_BITS){1'b0}}};
    case (idx)
      3'h0: rd_byte = res_hi_q;
      3'h1: rd_byte = res_lo_q;
      3'h2: rd_byte = {2'b00, channel_select, start_q, enable_q};
      3'h3: rd_byte = {2'b00, negative_reference_select, positive_reference_select,
                       analog_pin_config};
      `ADCSEQ_IDX_TIMING_FORMAT: rd_byte = {justify_q, 1'b0, acq_sel_q, clk_sel_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // bus slave: one wait cycle, unmapped reads zero, writes ignored
  always @(posedge core_clk) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~req_first;
      if (rd_first) begin
        avs_readdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // result pair has only a power-on clear, not the ordinary reset
  always @(posedge core_clk) begin
    if (!por_b) begin
      res_hi_q <= 8'h00;
      res_lo_q <= 8'h00;
    end else if (conv_done && start_q && !sw_clear) begin
      // an abort in the completing cycle must not land a result
      res_hi_q <= result_word[15:8];
      res_lo_q <= result_word[7:0];
    end else if (wr_res_hi) begin
      res_hi_q <= avs_writedata[7:0];
    end else if (wr_res_lo) begin
      res_lo_q <= avs_writedata[7:0];
    end
  end

  always @(posedge core_clk) begin
    if (!rst_b) begin
      // strap chooses reset pin config at each edge while reset is held
      enable_q <= 1'b0;
      start_q <= 1'b0;
      justify_q <= 1'b0;
      acq_sel_q <= 3'h0;
      clk_sel_q <= 3'h0;
      channel_select <= 4'h0;
      negative_reference_select <= 1'b0;
      positive_reference_select <= 1'b0;
      analog_pin_config <= portb_analog_reset_config ? `ADCSEQ_PCFG_ANALOG
                                                      : `ADCSEQ_PCFG_DIGITAL;
      state_q <= ST_IDLE;
      tcy_cnt_q <= 8'h00;
      tad_cnt_q <= 8'h00;
      step_q <= 5'h00;
      sar_q <= {RES_BITS{1'b0}};
      conversion_complete_flag <= 1'b0;
      timer_counter_clear <= 1'b0;
      sample_switch_closed <= 1'b0;
      holding_discharge <= 1'b0;
      dac_code <= {RES_BITS{1'b0}};
      port_read_value <= {NPINS{1'b0}};
    end else begin
      timer_counter_clear <= trig_mode & special_event_trigger;
      for (i = 0; i < NPINS; i = i + 1) begin
        port_read_value[i] <= pin_analog(analog_pin_config, i) ? 1'b0
                                                               : pin_digital_in[i];
      end
      tcy_cnt_q <= tcy_tick ? 8'h00 : tcy_cnt_q + 8'h01;
      tad_cnt_q <= (tad_tick || state_q == ST_IDLE) ? 8'h00 : tad_cnt_q + 8'h01;
      if (wr_ctl) begin
        enable_q <= avs_writedata[`ADCSEQ_BIT_ENABLE];
        channel_select <= avs_writedata[`ADCSEQ_CHAN_LSB+3:`ADCSEQ_CHAN_LSB];
      end

      if (wr_ref) begin
        negative_reference_select <= avs_writedata[`ADCSEQ_REF_NEG_BIT];
        positive_reference_select <= avs_writedata[`ADCSEQ_REF_POS_BIT];
        analog_pin_config <= avs_writedata[3:0];
      end

      if (wr_timing) begin
        justify_q <= avs_writedata[`ADCSEQ_BIT_JUSTIFY];
        acq_sel_q <= avs_writedata[`ADCSEQ_ACQ_LSB+2:`ADCSEQ_ACQ_LSB];
        clk_sel_q <= avs_writedata[2:0];
      end

      if (wr_flag) begin
        conversion_complete_flag <= avs_writedata[0];
      end
      // start needs the converter on before this write
      if (start_req) begin
        start_q <= 1'b1;
      end else if (sw_clear) begin
        start_q <= 1'b0;
      end

      case (state_q)
        ST_IDLE: begin
          // empty the holding array for one cycle before each idle sample
          if (enable_q && !sample_switch_closed && !holding_discharge) begin
            holding_discharge <= 1'b1;
          end else if (holding_discharge) begin
            holding_discharge <= 1'b0;
            sample_switch_closed <= enable_q;
          end
          if (start_req) begin
            holding_discharge <= 1'b0;
            state_q <= (acq_sel_q == 3'h0) ? ST_DELAY : ST_DISCH;
            step_q <= acq_len;
          end
        end
        ST_DELAY: begin
          if (tcy_tick) begin
            state_q <= ST_CONV;
            sample_switch_closed <= 1'b0;
            sar_q <= SAR_FIRST;
            dac_code <= SAR_FIRST;
            step_q <= RES_BITS[4:0];
          end
        end
        ST_DISCH: begin
          holding_discharge <= 1'b1;
          sample_switch_closed <= 1'b0;
          if (tad_tick) begin
            holding_discharge <= 1'b0;
            sample_switch_closed <= 1'b1;
            state_q <= ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (tad_tick) begin
            if (step_q == 5'h01) begin
              state_q <= ST_CONV;
              sample_switch_closed <= 1'b0;
              sar_q <= SAR_FIRST;
              dac_code <= SAR_FIRST;
              step_q <= RES_BITS[4:0];
            end else begin
              step_q <= step_q - 5'h01;
            end
          end
        end
        ST_CONV: begin
          if (sw_clear) begin
            state_q <= ST_WAIT;
            step_q <= RESTART_STEPS;
          end else if (tad_tick) begin
            if (step_q == 5'h00) begin
              start_q <= 1'b0;
              conversion_complete_flag <= 1'b1;
              state_q <= ST_WAIT;
              step_q <= RESTART_STEPS;
            end else begin
              // one bit decided per bit period
              sar_q <= sar_next(sar_q, dac_code, comparator_high);
              dac_code <= sar_next(sar_q, dac_code, comparator_high);
              step_q <= step_q - 5'h01;
            end
          end
        end
        ST_WAIT: begin
          // switch stays open; idle discharges before it samples again
          if (tcy_tick) begin
            if (step_q == 5'h01) begin
              state_q <= ST_IDLE;
            end else begin
              step_q <= step_q - 5'h01;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase

      // abort also covers delay, discharge and acquisition phases
      if (sw_clear && busy) begin
        state_q <= ST_WAIT;
        step_q <= RESTART_STEPS;
        holding_discharge <= 1'b0;
        sample_switch_closed <= 1'b0;
      end

      if (!enable_q) begin
        sample_switch_closed <= 1'b0;
      end
    end
  end
endmodule // adcseq_core

// >>> test/adcseq_chk.sv
// Purpose: port-level checks of the conversion sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the core below its endmodule
module adcseq_chk #(
  parameter NPINS = 13
) (
  input wire core_clk,
  input wire rst_b,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire portb_analog_reset_config,
  input wire [3:0] second_capture_compare_mode,
  input wire special_event_trigger,
  input wire [NPINS-1:0] port_read_value,
  input wire timer_counter_clear,
  input wire conversion_complete_flag,
  input wire sample_switch_closed,
  input wire holding_discharge,
  input wire [3:0] channel_select,
  input wire [3:0] analog_pin_config
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // saturating age of the last discharge, so a stale one cannot count
  logic [3:0] disch_age_q;
  always @(posedge core_clk) begin
    if (!rst_b) disch_age_q <= 4'hF;
    else if (holding_discharge) disch_age_q <= 4'h0;
    else if (disch_age_q != 4'hF) disch_age_q <= disch_age_q + 4'h1;
  end
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("no bus answer one cycle after request");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer held longer than one cycle");
  a_trig_clear: assert property (special_event_trigger && second_capture_compare_mode == 4'hB
    |=> timer_counter_clear) else $error("trigger did not clear timer");
  a_clear_cause: assert property (timer_counter_clear |-> $past(special_event_trigger)
    && $past(second_capture_compare_mode) == 4'hB) else $error("timer clear without trigger");
  a_reset_cfg: assert property ($rose(rst_b) |-> channel_select == 4'h0
    && !conversion_complete_flag
    && analog_pin_config == ($past(portb_analog_reset_config) ? 4'h0 : 4'h7))
    else $error("control state wrong after reset");
  a_port_analog: assert property (analog_pin_config == 4'h0
    && $past(analog_pin_config) == 4'h0 |-> port_read_value == '0)
    else $error("analog pin reads nonzero");
  a_discharge_first: assert property ($rose(sample_switch_closed)
    |-> disch_age_q != 4'hF || holding_discharge) else $error("sample without discharge");
  a_flag_sticky: assert property (conversion_complete_flag
    && !(avs_write && avs_address[4:2] == 3'h7) |=> conversion_complete_flag)
    else $error("complete flag dropped by itself");
endmodule // adcseq_chk

bind adcseq_core adcseq_chk #(.NPINS(NPINS)) u_chk (.core_clk, .rst_b, .avs_address,
  .avs_read, .avs_write, .avs_waitrequest, .portb_analog_reset_config,
  .second_capture_compare_mode, .special_event_trigger, .port_read_value,
  .timer_counter_clear, .conversion_complete_flag, .sample_switch_closed,
  .holding_discharge, .channel_select, .analog_pin_config);

// >>> test/test_adc_conversion_sequencer.sv
// Purpose: self-checking bench of the conversion sequencer
// Assumes: 50 MHz clock, Avalon-MM with one wait cycle
// Notes: comparator held high gives an all-ones result
module test_adc_conversion_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_b, por_b, avs_read, avs_write, avs_waitrequest;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic portb_analog_reset_config, special_event_trigger, comparator_high;
  logic [3:0] second_capture_compare_mode, channel_select, analog_pin_config;
  logic [12:0] pin_digital_in, port_read_value;
  logic timer_counter_clear, conversion_complete_flag, sample_switch_closed;
  logic holding_discharge, negative_reference_select, positive_reference_select;
  logic [11:0] dac_code;
  logic [7:0] rd;
  int n_fail, num_checks;
  adcseq_core DUT (.core_clk, .rst_b, .por_b, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .portb_analog_reset_config,
    .second_capture_compare_mode, .special_event_trigger, .pin_digital_in,
    .comparator_high, .port_read_value, .timer_counter_clear, .conversion_complete_flag,
    .sample_switch_closed, .holding_discharge, .dac_code, .channel_select,
    .negative_reference_select, .positive_reference_select, .analog_pin_config);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // whole run is under 10k cycles; 50k cycles cuts a hang
  initial begin
    #1ms;
    n_fail++;
    results;
  end
  task results;
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h000000, d};
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wait_flag;
    for (int i = 0; i < 20000 && conversion_complete_flag !== 1'b1; i++) @(posedge core_clk);
  endtask
  task pulse;
    @(posedge core_clk);
    special_event_trigger <= 1'b1;
    @(posedge core_clk);
    special_event_trigger <= 1'b0;
    #1;
  endtask
  task t_reset;
    chk(analog_pin_config, 4'h0);
    bus(1'b0, 6'h08, 8'h00); chk(rd, 8'h00);
    bus(1'b0, 6'h10, 8'h00); chk(rd, 8'h00);
  endtask
  task t_ports;
    logic [12:0] exp;
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, 6'h0C, {2'b00, c[1:0], c[3:0]});
      repeat (3) @(posedge core_clk);
      exp = pin_digital_in & (32'hFFFFFFFF << (15 - c));
      chk(port_read_value, exp);
      chk({negative_reference_select, positive_reference_select}, c[1:0]);
    end
  endtask
  task t_conv(input logic [7:0] tcfg, input logic cmp, input logic [7:0] eh, el);
    comparator_high <= cmp;
    bus(1'b1, 6'h1C, 8'h00);
    bus(1'b1, 6'h10, tcfg);
    bus(1'b1, 6'h08, 8'h05);
    repeat (100) @(posedge core_clk);
    chk(channel_select, 4'h1);
    bus(1'b1, 6'h08, 8'h07);
    wait_flag;
    chk(conversion_complete_flag, 1'b1);
    bus(1'b0, 6'h08, 8'h00); chk(rd, 8'h05);
    bus(1'b0, 6'h00, 8'h00); chk(rd, eh);
    bus(1'b0, 6'h04, 8'h00); chk(rd, el);
    chk({20'h0_0000, dac_code}, cmp ? 32'h0000_0FFF : 32'h0000_0000);
  endtask
  task t_abort;
    bus(1'b1, 6'h00, 8'h5A);
    bus(1'b1, 6'h04, 8'hA5);
    bus(1'b1, 6'h1C, 8'h00);
    bus(1'b1, 6'h08, 8'h03);
    repeat (50) @(posedge core_clk);
    bus(1'b1, 6'h08, 8'h01);
    repeat (30) @(posedge core_clk);
    chk(sample_switch_closed, 1'b1);
    repeat (3000) @(posedge core_clk);
    chk(conversion_complete_flag, 1'b0);
    bus(1'b0, 6'h00, 8'h00); chk(rd, 8'h5A);
    bus(1'b0, 6'h04, 8'h00); chk(rd, 8'hA5);
  endtask
  task t_trig;
    bus(1'b1, 6'h1C, 8'h00);
    bus(1'b1, 6'h10, 8'h90);
    bus(1'b1, 6'h08, 8'h01);
    second_capture_compare_mode <= 4'hB;
    pulse; chk(timer_counter_clear, 1'b1);
    wait_flag; chk(conversion_complete_flag, 1'b1);
    bus(1'b1, 6'h08, 8'h00);
    bus(1'b1, 6'h1C, 8'h00);
    pulse; chk(timer_counter_clear, 1'b1);
    repeat (600) @(posedge core_clk);
    chk(conversion_complete_flag, 1'b0);
    second_capture_compare_mode <= 4'h3;
    pulse; chk(timer_counter_clear, 1'b0);
  endtask
  task t_midreset;
    bus(1'b1, 6'h00, 8'h3C);
    bus(1'b1, 6'h04, 8'hC3);
    bus(1'b1, 6'h08, 8'h01);
    bus(1'b1, 6'h08, 8'h03);
    repeat (20) @(posedge core_clk);
    portb_analog_reset_config <= 1'b0;
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    portb_analog_reset_config <= 1'b1;
    #1 chk(analog_pin_config, 4'h7);
    bus(1'b0, 6'h08, 8'h00); chk(rd, 8'h00);
    bus(1'b0, 6'h00, 8'h00); chk(rd, 8'h3C);
    bus(1'b0, 6'h04, 8'h00); chk(rd, 8'hC3);
  endtask
  initial begin
    {rst_b, por_b, avs_read, avs_write, special_event_trigger} = 5'h00;
    avs_address = 6'h00;
    avs_writedata = 32'h00000000;
    portb_analog_reset_config = 1'b1;
    second_capture_compare_mode = 4'h0;
    pin_digital_in = 13'h15A5;
    comparator_high = 1'b1;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    t_reset;
    t_ports;
    for (int a = 0; a < 8; a++) t_conv({2'b10, a[2:0], 3'h0}, 1'b1, 8'h0F, 8'hFF);
    t_conv(8'h1B, 1'b1, 8'hFF, 8'hF0);
    t_conv(8'h96, 1'b0, 8'h00, 8'h00);
    t_abort;
    t_trig;
    t_midreset;
    results;
  end
endmodule // test_adc_conversion_sequencer
